// File: logic/hbs_brake_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "hbs_params.svh"
module hbs_brake_seq #(
	parameter logic [`HBS_TICK_W-1:0] TICK_CYCLES = `HBS_TICK_W'(`HBS_TICK_CYCLES)
) (
	input  wire logic                                 ref_clk,
	input  wire logic                                 rst,
	input  wire logic [`HBS_NUM_DI-1:0]               digitalIn,
	input  wire logic [`HBS_NUM_DI*`HBS_FUNC_W-1:0]   inputFunctionSelectors,
	input  wire logic [`HBS_NUM_DO*`HBS_FUNC_W-1:0]   outputFunctionSelectors,
	input  wire logic [`HBS_DELAY_W-1:0]              brakeReleaseDelay,
	input  wire logic [`HBS_DELAY_W-1:0]              brakeEngageDelay,
	input  wire logic [`HBS_SPEED_W-1:0]              zeroSpeedThreshold,
	input  wire logic [`HBS_SPEED_W-1:0]              motorSpeed,
	output logic                                      motorCurrentOn,
	output logic                                      brakeControlOutput,
	output logic [`HBS_NUM_DO-1:0]                    digitalOut
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [`HBS_NUM_DI-1:0]  dinMeta;
		logic [`HBS_NUM_DI-1:0]  dinSync;
		logic                    enPrev;
		hbs_pkg::hbs_state_t     state;
		logic [`HBS_DELAY_W-1:0] msCnt;
		logic                    current;
		logic                    brake;
		logic [`HBS_NUM_DO-1:0]  dout;
	} hbs_state_s_t;

	hbs_state_s_t st_reg;
	hbs_state_s_t st_next;
	logic         enRaw;
	logic         enEdge;
	logic         tick;
	logic [`HBS_NUM_DO-1:0] doSel;

	// ----------------------------------------
	// Input decode
	// ----------------------------------------
	// Servo enable is any synchronised input whose selector is code 01
	always_comb
	begin
		enRaw = 1'b0;
		for (int i = 0; i < `HBS_NUM_DI; i++)
			if (inputFunctionSelectors[i*`HBS_FUNC_W +: `HBS_FUNC_W] == `HBS_FUNC_W'(`HBS_FUNC_ENABLE))
				enRaw = enRaw | st_reg.dinSync[i];
	end

	// Brake function routed to each output programmed with code 08
	genvar g;
	generate
		for (g = 0; g < `HBS_NUM_DO; g++)
		begin : gDo
			assign doSel[g] = outputFunctionSelectors[g*`HBS_FUNC_W +: `HBS_FUNC_W]
				== `HBS_FUNC_W'(`HBS_FUNC_BRAKE);
		end
	endgenerate

	// Either edge of the synchronised enable restarts both timers
	assign enEdge = enRaw ^ st_reg.enPrev;

	// Millisecond time base for both delays
	hbs_ms_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) hbs_ms_tick_inst (
		.ref_clk (ref_clk),
		.rst     (rst),
		.restart (enEdge),
		.tick    (tick)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Next state of the brake sequence
	always_comb
	begin
		st_next = st_reg;
		// Two-flop synchroniser on the raw pins, then edge memory
		st_next.dinMeta = digitalIn;
		st_next.dinSync = st_reg.dinMeta;
		st_next.enPrev = enRaw;
		if (enEdge)
			st_next.msCnt = '0;
		else if (tick && st_reg.msCnt != '1)
			st_next.msCnt = st_reg.msCnt + `HBS_DELAY_W'(1);
		unique case (st_reg.state)
			hbs_pkg::HBS_OFF:
			begin
				st_next.current = 1'b0;
				st_next.brake = 1'b0;
				// Enable rise applies current, brake still holds
				if (enRaw && enEdge)
				begin
					st_next.state = hbs_pkg::HBS_RELEASE_WAIT;
					st_next.current = 1'b1;
				end
			end
			hbs_pkg::HBS_RELEASE_WAIT:
			begin
				// Enable lost before release drops current at once
				if (!enRaw)
				begin
					st_next.state = hbs_pkg::HBS_OFF;
					st_next.current = 1'b0;
				end
				else if (!enEdge && st_reg.msCnt >= brakeReleaseDelay)
				begin
					st_next.state = hbs_pkg::HBS_RUN;
					st_next.brake = 1'b1;
				end
			end
			hbs_pkg::HBS_RUN:
			begin
				if (!enRaw)
					st_next.state = hbs_pkg::HBS_ENGAGE_WAIT;
			end
			hbs_pkg::HBS_ENGAGE_WAIT:
			begin
				// Enable back before the stop keeps the brake released
				if (enRaw && enEdge)
					st_next.state = hbs_pkg::HBS_RUN;
				else if (!enEdge && (st_reg.msCnt >= brakeEngageDelay
					|| motorSpeed < zeroSpeedThreshold))
				begin
					st_next.state = hbs_pkg::HBS_OFF;
					st_next.brake = 1'b0;
					st_next.current = 1'b0;
				end
			end
		endcase
		st_next.dout = doSel & {`HBS_NUM_DO{st_next.brake}};
	end

	// State register, synchronous reset to the idle state
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st_reg <= '0;
			st_reg.state <= hbs_pkg::HBS_OFF;
		end
		else
			st_reg <= st_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// All outputs straight from flip-flops
	assign motorCurrentOn = st_reg.current;
	assign brakeControlOutput = st_reg.brake;
	assign digitalOut = st_reg.dout;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Release and engage ordering
	a_brake_needs_current: assert property (@(posedge ref_clk) disable iff (rst)
		brakeControlOutput |-> motorCurrentOn)
		else $error("brake released without current");
	a_release_waits: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(brakeControlOutput) |-> $past(st_reg.msCnt) >= brakeReleaseDelay)
		else $error("brake released before delay");
	a_current_drop: assert property (@(posedge ref_clk) disable iff (rst)
		($fell(motorCurrentOn) && $past(st_reg.state) == hbs_pkg::HBS_ENGAGE_WAIT) |-> $fell(brakeControlOutput))
		else $error("current dropped apart from brake");
	// Stop conditions of the engage wait
	a_speed_stop: assert property (@(posedge ref_clk) disable iff (rst)
		(st_reg.state == hbs_pkg::HBS_ENGAGE_WAIT && !enEdge && !enRaw
			&& motorSpeed < zeroSpeedThreshold) |=> !brakeControlOutput)
		else $error("brake not engaged at zero speed");
	a_delay_stop: assert property (@(posedge ref_clk) disable iff (rst)
		(st_reg.state == hbs_pkg::HBS_ENGAGE_WAIT && !enEdge && !enRaw
			&& st_reg.msCnt >= brakeEngageDelay) |=> !brakeControlOutput)
		else $error("brake not engaged after delay");
	// Pin routing, idle state and timer restart
	a_pin_route: assert property (@(posedge ref_clk) disable iff (rst)
		digitalOut == (doSel & {`HBS_NUM_DO{brakeControlOutput}}) || $changed(outputFunctionSelectors))
		else $error("brake pin routing wrong");
	a_off_holds: assert property (@(posedge ref_clk) disable iff (rst)
		(st_reg.state == hbs_pkg::HBS_OFF) |-> !brakeControlOutput && !motorCurrentOn)
		else $error("off state not holding");
	a_timer_restart: assert property (@(posedge ref_clk) disable iff (rst)
		enEdge |=> st_reg.msCnt == '0)
		else $error("timer not restarted");

	// Per-state output levels, and the timer holding without a tick
	a_release_hold: assert property (@(posedge ref_clk) disable iff (rst)
		(st_reg.state == hbs_pkg::HBS_RELEASE_WAIT) |-> !brakeControlOutput)
		else $error("brake released inside release wait");
	a_current_start: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(motorCurrentOn) |-> !brakeControlOutput)
		else $error("current and brake changed together");
	a_brake_source: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(brakeControlOutput) |-> $past(st_reg.state) == hbs_pkg::HBS_RELEASE_WAIT)
		else $error("brake released outside release wait");
	a_run_holds: assert property (@(posedge ref_clk) disable iff (rst)
		(st_reg.state == hbs_pkg::HBS_RUN) |-> motorCurrentOn && brakeControlOutput)
		else $error("run state outputs wrong");
	a_engage_current: assert property (@(posedge ref_clk) disable iff (rst)
		(st_reg.state == hbs_pkg::HBS_ENGAGE_WAIT) |-> motorCurrentOn && brakeControlOutput)
		else $error("engage wait outputs wrong");
	a_engage_hold: assert property (@(posedge ref_clk) disable iff (rst)
		(st_reg.state == hbs_pkg::HBS_ENGAGE_WAIT && st_reg.msCnt < brakeEngageDelay
			&& motorSpeed >= zeroSpeedThreshold) |=> motorCurrentOn)
		else $error("current removed before engage delay");
	a_abort_release: assert property (@(posedge ref_clk) disable iff (rst)
		(st_reg.state == hbs_pkg::HBS_RELEASE_WAIT && !enRaw) |=> !motorCurrentOn)
		else $error("current kept after enable lost");
	a_resume_run: assert property (@(posedge ref_clk) disable iff (rst)
		(st_reg.state == hbs_pkg::HBS_ENGAGE_WAIT && enRaw && enEdge)
			|=> st_reg.state == hbs_pkg::HBS_RUN && brakeControlOutput)
		else $error("enable return did not resume run");
	a_off_idle: assert property (@(posedge ref_clk) disable iff (rst)
		(st_reg.state == hbs_pkg::HBS_OFF && !(enRaw && enEdge)) |=> !motorCurrentOn)
		else $error("current applied without enable");
	a_timer_count: assert property (@(posedge ref_clk) disable iff (rst)
		(!enEdge && !tick) |=> st_reg.msCnt == $past(st_reg.msCnt))
		else $error("timer moved without tick");
endmodule : hbs_brake_seq
`default_nettype wire

// File: logic/hbs_ms_tick.sv
`timescale 1ns/10ps
`default_nettype none
`include "hbs_params.svh"
module hbs_ms_tick #(
	parameter logic [`HBS_TICK_W-1:0] TICK_CYCLES = `HBS_TICK_W'(`HBS_TICK_CYCLES)
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic restart,
	output logic      tick
);
	typedef struct packed {
		logic [`HBS_TICK_W-1:0] cnt;
		logic                   tick;
	} hbs_tick_state_t;

	hbs_tick_state_t st_reg;
	hbs_tick_state_t st_next;

	// Free millisecond prescaler, realigned on restart
	always_comb
	begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (restart || st_reg.cnt == TICK_CYCLES - `HBS_TICK_W'(1))
		begin
			st_next.cnt = '0;
			st_next.tick = !restart;
		end
		else
			st_next.cnt = st_reg.cnt + `HBS_TICK_W'(1);
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign tick = st_reg.tick;
endmodule : hbs_ms_tick
`default_nettype wire

// File: logic/hbs_params.svh
`ifndef HBS_PARAMS_SVH
`define HBS_PARAMS_SVH
`define HBS_FUNC_BRAKE      4'h8
`define HBS_FUNC_ENABLE     4'h1
`define HBS_FUNC_W          4
`define HBS_NUM_DO          5
`define HBS_NUM_DI          8
`define HBS_DELAY_W         16
`define HBS_SPEED_W         16
// Delays are given in milliseconds; one ms at 100 MHz
`define HBS_CLK_MHZ         100
`define HBS_MS_NS           1000000
`define HBS_CLK_NS          10
`define HBS_TICK_CYCLES     (`HBS_MS_NS / `HBS_CLK_NS)
`define HBS_TICK_W          17
`endif

// File: logic/hbs_pkg.sv
`default_nettype none
package hbs_pkg;
	typedef enum logic [1:0] {
		HBS_OFF,
		HBS_RELEASE_WAIT,
		HBS_RUN,
		HBS_ENGAGE_WAIT
	} hbs_state_t;
endpackage : hbs_pkg
`default_nettype wire

// File: tb/hbs_relay.sv
`timescale 1ns/10ps
`default_nettype none
module hbs_relay (
	input  wire logic ref_clk,
	input  wire logic coil,
	output logic      brakeFree
);
	// Contacts follow the coil two cycles late
	logic [1:0] pipeReg;
	always_ff @(posedge ref_clk)
		pipeReg <= {pipeReg[0], coil};
	assign brakeFree = pipeReg[1];
endmodule : hbs_relay
`default_nettype wire

// File: tb/holding_brake_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module holding_brake_sequencer_tb;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  digitalIn = 8'h00;
	logic [15:0] speed = 16'h0100;
	logic [19:0] outSel = 20'h08002;
	logic [4:0]  brakePins = 5'h08;
	logic        motorCurrentOn;
	logic        brakeControlOutput;
	logic        brakeFree;
	logic [4:0]  digitalOut;
	int          errors = 0;
	int          cmp_count = 0;
	// Input 2 is enable, output 3 carries the brake, output 0 another code
	hbs_brake_seq #(.TICK_CYCLES(17'h0000a)) hbs_brake_seq_inst (
		.ref_clk(ref_clk), .rst(rst), .digitalIn(digitalIn),
		.inputFunctionSelectors(32'h00000100), .outputFunctionSelectors(outSel),
		.brakeReleaseDelay(16'h0003), .brakeEngageDelay(16'h0004),
		.zeroSpeedThreshold(16'h0010), .motorSpeed(speed), .motorCurrentOn(motorCurrentOn),
		.brakeControlOutput(brakeControlOutput), .digitalOut(digitalOut));
	hbs_relay hbs_relay_inst (.ref_clk(ref_clk), .coil(digitalOut[3]), .brakeFree(brakeFree));
	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic waitc(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : waitc
	// Compares current, brake and all outputs pins
	task automatic expect_out(string name, logic mc, logic br);
		cmp_count++;
		if ({mc, br, brakePins & {5{br}}} !== {motorCurrentOn, brakeControlOutput, digitalOut})
		begin
			errors++;
			$display("Error %s expected %h seen %h", name, {mc, br, brakePins & {5{br}}},
				{motorCurrentOn, brakeControlOutput, digitalOut});
		end
	endtask : expect_out
	// Compares the relay contact state
	task automatic expect_relay(string name, logic fr);
		cmp_count++;
		if (brakeFree !== fr)
		begin
			errors++;
			$display("Error %s expected %b seen %b", name, fr, brakeFree);
		end
	endtask : expect_relay
	task automatic results();
		$display("Comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	// Release waits its delay, then pin 3 follows
	task automatic test_release();
		digitalIn[2] = 1'b1;
		waitc(20);
		expect_out("release_wait", 1'b1, 1'b0);
		waitc(25);
		expect_out("released", 1'b1, 1'b1);
		expect_relay("relay_released", 1'b1);
		$display("test release done");
	endtask : test_release
	// Brake moved to outputs 1 and 4, then back to output 3
	task automatic test_pin_route();
		outSel = 20'h80082;
		brakePins = 5'h12;
		waitc(2);
		expect_out("pins_moved", 1'b1, 1'b1);
		waitc(2);
		expect_relay("relay_unrouted", 1'b0);
		outSel = 20'h08002;
		brakePins = 5'h08;
		waitc(4);
		expect_out("pins_back", 1'b1, 1'b1);
		$display("test pin_route done");
	endtask : test_pin_route
	// Enable back inside the engage wait keeps the run going
	task automatic test_engage_resume();
		digitalIn[2] = 1'b0;
		waitc(6);
		expect_out("engage_hold", 1'b1, 1'b1);
		digitalIn[2] = 1'b1;
		waitc(60);
		expect_out("resumed", 1'b1, 1'b1);
		$display("test engage_resume done");
	endtask : test_engage_resume
	// Speed stays high, engage delay alone ends the run
	task automatic test_engage_timeout();
		digitalIn[2] = 1'b0;
		waitc(20);
		expect_out("engage_wait", 1'b1, 1'b1);
		waitc(30);
		expect_out("engaged", 1'b0, 1'b0);
		expect_relay("relay_engaged", 1'b0);
		$display("test engage_timeout done");
	endtask : test_engage_timeout
	// Low speed ends the engage wait early
	task automatic test_stop_speed();
		digitalIn[2] = 1'b1;
		waitc(50);
		expect_out("run", 1'b1, 1'b1);
		speed = 16'h0005;
		digitalIn[2] = 1'b0;
		waitc(10);
		expect_out("stopped", 1'b0, 1'b0);
		expect_relay("relay_stopped", 1'b0);
		speed = 16'h0100;
		$display("test stop_speed done");
	endtask : test_stop_speed
	// Enable dropped inside the release wait, then reset mid-run with enable held
	task automatic test_abort_reset();
		digitalIn[2] = 1'b1;
		waitc(12);
		expect_out("release_started", 1'b1, 1'b0);
		digitalIn[2] = 1'b0;
		waitc(8);
		expect_out("aborted", 1'b0, 1'b0);
		digitalIn[2] = 1'b1;
		waitc(50);
		rst = 1'b1;
		waitc(3);
		expect_out("in_reset", 1'b0, 1'b0);
		rst = 1'b0;
		waitc(5);
		expect_out("after_reset", 1'b1, 1'b0);
		waitc(40);
		expect_out("after_reset_release", 1'b1, 1'b1);
		$display("test abort_reset done");
	endtask : test_abort_reset
	initial
	begin
		waitc(3);
		rst = 1'b0;
		expect_out("reset", 1'b0, 1'b0);
		test_release();
		test_pin_route();
		test_engage_resume();
		test_engage_timeout();
		test_stop_speed();
		test_abort_reset();
		results();
	end
	// Watchdog well past the few hundred cycles the tests need
	initial
	begin
		#20000;
		errors++;
		results();
	end
endmodule : holding_brake_sequencer_tb
`default_nettype wire
